// ==== rlsr_pkg.sv ====
`default_nettype none
package rlsr_pkg;
  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [7:0] ADR_CTRL   = 8'h00;
  localparam logic [7:0] ADR_STATUS = 8'h04;
  localparam logic [7:0] ADR_CMD    = 8'h08;
  localparam logic [7:0] ADR_POST   = 8'h0C;
  localparam logic [7:0] ADR_ERRQ   = 8'h10;
  localparam int CTRL_SRE  = 0;
  localparam int CTRL_URE  = 1;
  localparam int CTRL_BUSY = 2;
  localparam int CTRL_ADDR = 8;
  localparam int CMD_EXEC  = 2;
  localparam logic [4:0] ADDR_RST = 5'h10;
  localparam logic [1:0] KIND_QUERY   = 2'h0;
  localparam logic [1:0] KIND_SETTING = 2'h1;
  // ------------------------------------------------------------
  // interface message bytes (with atn)
  // ------------------------------------------------------------
  localparam logic [7:0] GP_GTL = 8'h01;
  localparam logic [7:0] GP_SDC = 8'h04;
  localparam logic [7:0] GP_LLO = 8'h11;
  localparam logic [7:0] GP_DCL = 8'h14;
  localparam logic [7:0] GP_SPE = 8'h18;
  localparam logic [7:0] GP_SPD = 8'h19;
  localparam logic [7:0] GP_UNL = 8'h3F;
  localparam logic [7:0] GP_UNT = 8'h5F;
  localparam logic [7:0] GP_MLA = 8'h20;
  localparam logic [7:0] GP_MTA = 8'h40;
  // ------------------------------------------------------------
  // error codes
  // ------------------------------------------------------------
  localparam int CW = 10;
  localparam logic [9:0] C_CMD_LO  = 10'h065;
  localparam logic [9:0] C_CMD_HI  = 10'h06A;
  localparam logic [9:0] C_LOCAL   = 10'h0C9;
  localparam logic [9:0] C_RTL     = 10'h0CA;
  localparam logic [9:0] C_PWR     = 10'h191;
  localparam logic [9:0] C_OPC     = 10'h192;
  localparam logic [9:0] C_USR     = 10'h193;
  localparam logic [9:0] C_FULL    = 10'h1C2;
  localparam logic [9:0] C_HALF    = 10'h1C3;
  localparam logic [9:0] C_RDY     = 10'h1C4;
  localparam logic [9:0] C_IERR    = 10'h1C5;
  localparam logic [9:0] C_OVF     = 10'h1C6;
  localparam logic [9:0] C_EWRN_LO = 10'h1F4;
  localparam logic [9:0] C_EWRN_HI = 10'h257;
  localparam logic [9:0] C_IWRN_LO = 10'h258;
  localparam logic [9:0] C_IWRN_HI = 10'h2BB;
  // event inputs: opc usr full half rdy ovf hwfail iwarn
  localparam int NEVT = 8;
  localparam int EVT_USR = 1;
  localparam logic [7:0][9:0] EVT_CODE = {10'h28A, C_IERR, C_OVF, C_RDY,
                                          C_HALF, C_FULL, C_USR, C_OPC};
  // ------------------------------------------------------------
  // status classes, index = priority (0 highest)
  // ------------------------------------------------------------
  localparam int NCL     = 12;
  localparam int CL_PWR  = 0;
  localparam int CL_CMD  = 1;
  localparam int CL_EXE  = 2;
  localparam int CL_USR  = 3;
  localparam int CL_FULL = 4;
  localparam int CL_HALF = 5;
  localparam int CL_OPC  = 6;
  localparam int CL_RDY  = 7;
  localparam int CL_EWRN = 8;
  localparam int CL_IWRN = 9;
  localparam int CL_IERR = 10;
  localparam int CL_OVF  = 11;
  localparam logic [11:0][7:0] STB_BASE = {8'hC9, 8'h63, 8'h66, 8'h65,
    8'hC8, 8'h42, 8'hC7, 8'hC6, 8'h43, 8'h62, 8'h61, 8'h41};
  localparam logic [7:0] STB_BUSY = 8'h10;
  localparam logic [7:0] STB_NONE = 8'h00;
  typedef enum logic [1:0] {
    local_state, remote_state, local_lockout_state, remote_lockout_state
  } rlsr_rl_type;
endpackage
`default_nettype wire

// ==== rlsr_q_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface rlsr_q_if #(parameter int W = 10);
  logic         push;
  logic [W-1:0] wdata;
  logic         pop;
  logic         flush;
  logic [W-1:0] rdata;
  logic         empty;
  logic         full;
  modport user (output push, wdata, pop, flush, input rdata, empty, full);
  modport mem  (input push, wdata, pop, flush, output rdata, empty, full);
endinterface
`default_nettype wire

// ==== rlsr_code_queue.sv ====
`timescale 1ns/1ps
`default_nettype none
module rlsr_code_queue #(
  parameter int W     = 10,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // queue port
  rlsr_q_if.mem    q
);
  localparam int AW = $clog2(DEPTH);
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_chk
    $error("queue depth must be a power of two, at least 2");
  end
  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] mem;
    logic [AW-1:0]           wp;
    logic [AW-1:0]           rp;
    logic [AW:0]             cnt;
    logic [W-1:0]            rdata;
  } rlsr_q_state_type;
  rlsr_q_state_type s;
  rlsr_q_state_type next_s;
  logic do_pop;
  logic do_push;
  // ------------------------------------------------------------
  // queue update
  // ------------------------------------------------------------
  always_comb begin
    next_s  = s;
    do_pop  = q.pop && (s.cnt != '0);
    do_push = q.push && ((s.cnt != (AW+1)'(DEPTH)) || do_pop);
    if (do_push) begin
      next_s.mem[s.wp] = q.wdata;
      next_s.wp        = s.wp + 1'b1;
    end
    if (do_pop) begin
      next_s.rp = s.rp + 1'b1;
    end
    next_s.cnt = s.cnt + (AW+1)'(do_push) - (AW+1)'(do_pop);
    if (q.flush) begin
      next_s.wp  = '0;
      next_s.rp  = '0;
      next_s.cnt = '0;
    end
    next_s.rdata = next_s.mem[next_s.rp];
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
  assign q.rdata = s.rdata;
  assign q.empty = (s.cnt == '0);
  assign q.full  = (s.cnt == (AW+1)'(DEPTH));
endmodule
`default_nettype wire

// ==== rlsr_top.sv ====
// Our own choices: the register offsets and the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module rlsr_top #(
  parameter int QDEPTH = 8
) (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // gpib side
  input  wire logic        ren,
  input  wire logic        atn,
  input  wire logic        ifc,
  input  wire logic        bus_strobe,
  input  wire logic [7:0]  bus_byte,
  input  wire logic        poll_read,
  // front panel
  input  wire logic        key_press,
  input  wire logic        key_exempt,
  // device events
  input  wire logic [7:0]  evt,
  // status outputs
  output logic             srq,
  output logic      [7:0]  stb_byte,
  output logic             remote_ind,
  output logic             setting_en,
  output logic             listen_active,
  output logic             talk_active,
  output logic             poll_mode
);
  if (QDEPTH < 2) begin : g_chk
    $error("queue depth below 2");
  end
  typedef struct packed {
    rlsr_pkg::rlsr_rl_type rl;
    logic                  listen;
    logic                  talk;
    logic                  spe;
    logic                  service_request_enable;
    logic                  ure;
    logic                  busy;
    logic [4:0]            addr;
    logic                  executing;
    logic                  rejected;
    logic [11:0]           pend;
    logic [7:0]            stb;
    logic                  srq;
    logic                  remote;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
  } rlsr_state_type;
  rlsr_state_type s;
  rlsr_state_type next_s;
  rlsr_q_if #(.W(rlsr_pkg::CW)) q ();
  rlsr_code_queue #(.W(rlsr_pkg::CW), .DEPTH(QDEPTH)) u_queue (
    .pclk    (pclk),
    .presetn (presetn),
    .q       (q)
  );
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic [3:0] code_class(input logic [9:0] c);
    if (c >= rlsr_pkg::C_CMD_LO && c <= rlsr_pkg::C_CMD_HI) begin
      code_class = 4'(rlsr_pkg::CL_CMD);
    end else if (c == rlsr_pkg::C_PWR) begin
      code_class = 4'(rlsr_pkg::CL_PWR);
    end else if (c == rlsr_pkg::C_OPC) begin
      code_class = 4'(rlsr_pkg::CL_OPC);
    end else if (c == rlsr_pkg::C_USR) begin
      code_class = 4'(rlsr_pkg::CL_USR);
    end else if (c == rlsr_pkg::C_FULL) begin
      code_class = 4'(rlsr_pkg::CL_FULL);
    end else if (c == rlsr_pkg::C_HALF) begin
      code_class = 4'(rlsr_pkg::CL_HALF);
    end else if (c == rlsr_pkg::C_RDY) begin
      code_class = 4'(rlsr_pkg::CL_RDY);
    end else if (c == rlsr_pkg::C_IERR) begin
      code_class = 4'(rlsr_pkg::CL_IERR);
    end else if (c == rlsr_pkg::C_OVF) begin
      code_class = 4'(rlsr_pkg::CL_OVF);
    end else if (c >= rlsr_pkg::C_EWRN_LO && c <= rlsr_pkg::C_EWRN_HI) begin
      code_class = 4'(rlsr_pkg::CL_EWRN);
    end else if (c >= rlsr_pkg::C_IWRN_LO && c <= rlsr_pkg::C_IWRN_HI) begin
      code_class = 4'(rlsr_pkg::CL_IWRN);
    end else begin
      code_class = 4'(rlsr_pkg::CL_EXE);
    end
  endfunction
  function automatic logic [3:0] top_class(input logic [11:0] p);
    top_class = 4'(rlsr_pkg::NCL);
    for (int i = rlsr_pkg::NCL - 1; i >= 0; i--) begin
      if (p[i]) begin
        top_class = 4'(i);
      end
    end
  endfunction
  logic       setup;
  logic       acc;
  logic       msg;
  logic       mla;
  logic       mta;
  logic       gtl;
  logic       llo;
  logic       dcl;
  logic       key_force;
  logic       local_any;
  logic       post_v;
  logic [9:0] post_c;
  logic       hw_v;
  logic [9:0] hw_c;
  logic [11:0] set_v;
  logic [11:0] clr_v;
  logic [3:0] shown;
  logic [3:0] nshown;
  // ------------------------------------------------------------
  // next state
  // ------------------------------------------------------------
  always_comb begin
    next_s         = s;
    next_s.pready  = 1'b0;
    next_s.pslverr = 1'b0;
    setup     = psel && !penable && !s.pready;
    acc       = psel && penable && s.pready;
    msg       = bus_strobe && atn;
    mla       = msg && (bus_byte == (rlsr_pkg::GP_MLA | {3'h0, s.addr}));
    mta       = msg && (bus_byte == (rlsr_pkg::GP_MTA | {3'h0, s.addr}));
    gtl       = msg && (bus_byte == rlsr_pkg::GP_GTL) && s.listen;
    llo       = msg && (bus_byte == rlsr_pkg::GP_LLO);
    dcl       = msg && ((bus_byte == rlsr_pkg::GP_DCL) ||
                ((bus_byte == rlsr_pkg::GP_SDC) && s.listen));
    key_force = key_press && !key_exempt;
    local_any = (s.rl == rlsr_pkg::local_state) ||
                (s.rl == rlsr_pkg::local_lockout_state);
    hw_v      = 1'b0;
    hw_c      = rlsr_pkg::C_LOCAL;
    post_v    = 1'b0;
    post_c    = '0;
    set_v     = '0;
    clr_v     = '0;
    shown     = top_class(s.pend);
    // addressing
    if (mla) next_s.listen = 1'b1;
    if (mta) next_s.talk = 1'b1;
    if (msg && bus_byte == rlsr_pkg::GP_UNL) next_s.listen = 1'b0;
    if (msg && bus_byte == rlsr_pkg::GP_UNT) next_s.talk = 1'b0;
    if (msg && bus_byte == rlsr_pkg::GP_SPE) next_s.spe = 1'b1;
    if (msg && bus_byte == rlsr_pkg::GP_SPD) next_s.spe = 1'b0;
    if (ifc) begin
      next_s.listen = 1'b0;
      next_s.talk   = 1'b0;
      next_s.spe    = 1'b0;
    end
    // remote/local machine
    case (s.rl)
      rlsr_pkg::local_state: begin
        if (llo && ren) begin
          next_s.rl = rlsr_pkg::local_lockout_state;
        end else if (mla && ren && !key_press) begin
          next_s.rl = rlsr_pkg::remote_state;
        end
      end
      rlsr_pkg::remote_state: begin
        if (gtl || key_force) begin
          next_s.rl = rlsr_pkg::local_state;
          if (key_force && s.executing) begin
            hw_v = 1'b1;
            hw_c = rlsr_pkg::C_RTL;
            next_s.executing = 1'b0;
          end
        end else if (llo) begin
          next_s.rl = rlsr_pkg::remote_lockout_state;
        end
      end
      rlsr_pkg::local_lockout_state: begin
        if (mla && ren) begin
          next_s.rl = rlsr_pkg::remote_lockout_state;
        end
      end
      rlsr_pkg::remote_lockout_state: begin
        if (gtl) begin
          next_s.rl = rlsr_pkg::local_lockout_state;
        end
      end
      default: next_s.rl = rlsr_pkg::local_state;
    endcase
    if (!ren) begin
      next_s.rl = rlsr_pkg::local_state;
    end
    // apb read data, taken in the setup cycle
    if (setup) begin
      next_s.pready = 1'b1;
      next_s.prdata = '0;
      case (paddr)
        rlsr_pkg::ADR_CTRL: begin
          next_s.prdata[rlsr_pkg::CTRL_SRE]  = s.service_request_enable;
          next_s.prdata[rlsr_pkg::CTRL_URE]  = s.ure;
          next_s.prdata[rlsr_pkg::CTRL_BUSY] = s.busy;
          next_s.prdata[rlsr_pkg::CTRL_ADDR +: 5] = s.addr;
        end
        rlsr_pkg::ADR_STATUS: begin
          next_s.prdata[15:0] = {4'h0, s.pend};
          next_s.prdata[23:16] = s.stb;
          next_s.prdata[31:24] = {s.rejected, s.executing, s.spe, s.talk,
                                  s.listen, s.remote, 2'(s.rl)};
        end
        rlsr_pkg::ADR_CMD: next_s.prdata[0] = s.rejected;
        rlsr_pkg::ADR_POST: next_s.prdata = '0;
        rlsr_pkg::ADR_ERRQ: begin
          if (!q.empty) begin
            next_s.prdata[9:0] = q.rdata;
          end else if (s.pend[rlsr_pkg::CL_PWR]) begin
            next_s.prdata[9:0] = rlsr_pkg::C_PWR;
          end
        end
        default: next_s.pslverr = 1'b1;
      endcase
    end
    // apb access completion
    if (acc && pwrite) begin
      case (paddr)
        rlsr_pkg::ADR_CTRL: begin
          next_s.service_request_enable  = pwdata[rlsr_pkg::CTRL_SRE];
          next_s.ure  = pwdata[rlsr_pkg::CTRL_URE];
          next_s.busy = pwdata[rlsr_pkg::CTRL_BUSY];
          next_s.addr = pwdata[rlsr_pkg::CTRL_ADDR +: 5];
        end
        rlsr_pkg::ADR_CMD: begin
          if (pwdata[1:0] == rlsr_pkg::KIND_SETTING && local_any) begin
            next_s.rejected = 1'b1;
            hw_v = 1'b1;
            hw_c = rlsr_pkg::C_LOCAL;
          end else begin
            next_s.rejected  = 1'b0;
            next_s.executing = pwdata[rlsr_pkg::CMD_EXEC];
          end
        end
        rlsr_pkg::ADR_POST: begin
          post_v = 1'b1;
          post_c = pwdata[9:0];
          if (code_class(post_c) == 4'(rlsr_pkg::CL_CMD)) begin
            next_s.executing = 1'b0;
          end
        end
        default: ;
      endcase
    end
    if (acc && !pwrite && paddr == rlsr_pkg::ADR_ERRQ && !s.service_request_enable) begin
      clr_v[rlsr_pkg::CL_PWR] = 1'b1;
    end
    // status classes
    if (hw_v) set_v[code_class(hw_c)] = 1'b1;
    if (post_v) set_v[code_class(post_c)] = 1'b1;
    for (int i = 0; i < rlsr_pkg::NEVT; i++) begin
      if (evt[i] && (i != rlsr_pkg::EVT_USR || s.ure)) begin
        set_v[code_class(rlsr_pkg::EVT_CODE[i])] = 1'b1;
      end
    end
    if (poll_read && s.spe && s.talk && shown < 4'(rlsr_pkg::NCL)) begin
      if (shown != 4'(rlsr_pkg::CL_PWR) || s.service_request_enable) begin
        clr_v[shown] = 1'b1;
      end
    end
    if (dcl) begin
      clr_v = clr_v | ~12'h001;
    end
    next_s.pend = (s.pend & ~clr_v) | set_v;
    nshown = top_class(next_s.pend);
    if (nshown < 4'(rlsr_pkg::NCL)) begin
      next_s.stb = rlsr_pkg::STB_BASE[nshown];
    end else begin
      next_s.stb = rlsr_pkg::STB_NONE;
    end
    if (next_s.busy) begin
      next_s.stb = next_s.stb | rlsr_pkg::STB_BUSY;
    end
    next_s.srq = next_s.service_request_enable && (next_s.pend != '0);
    next_s.remote = (next_s.rl == rlsr_pkg::remote_state) ||
                    (next_s.rl == rlsr_pkg::remote_lockout_state);
  end
  // ------------------------------------------------------------
  // code queue feed
  // ------------------------------------------------------------
  logic [9:0] evt_code;
  logic       evt_v;
  always_comb begin
    evt_v    = 1'b0;
    evt_code = '0;
    for (int i = rlsr_pkg::NEVT - 1; i >= 0; i--) begin
      if (evt[i] && (i != rlsr_pkg::EVT_USR || s.ure)) begin
        evt_v    = 1'b1;
        evt_code = rlsr_pkg::EVT_CODE[i];
      end
    end
  end
  assign q.push  = hw_v || post_v || evt_v;
  assign q.wdata = hw_v ? hw_c : (post_v ? post_c : evt_code);
  assign q.pop   = acc && !pwrite && (paddr == rlsr_pkg::ADR_ERRQ);
  assign q.flush = dcl;
  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s      <= '0;
      s.rl   <= rlsr_pkg::local_state;
      s.service_request_enable  <= 1'b1;
      s.addr <= rlsr_pkg::ADDR_RST;
      s.pend <= 12'h001;
      s.stb  <= 8'h41;
      s.srq  <= 1'b1;
    end else begin
      s <= next_s;
    end
  end
  assign prdata        = s.prdata;
  assign pready        = s.pready;
  assign pslverr       = s.pslverr;
  assign srq           = s.srq;
  assign stb_byte      = s.stb;
  assign remote_ind    = s.remote;
  assign setting_en    = s.remote;
  assign listen_active = s.listen;
  assign talk_active   = s.talk;
  assign poll_mode     = s.spe;
  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  property p_ren_local;
    @(posedge pclk) disable iff (!presetn)
      !ren |=> (s.rl == rlsr_pkg::local_state) && !remote_ind;
  endproperty
  a_ren_local: assert property (p_ren_local) else $error("ren low not local");
  property p_go_remote;
    @(posedge pclk) disable iff (!presetn)
      (s.rl == rlsr_pkg::local_state) && ren && mla && !key_press && !llo
      |=> (s.rl == rlsr_pkg::remote_state) && remote_ind;
  endproperty
  a_go_remote: assert property (p_go_remote) else $error("no remote entry");
  property p_key_local;
    @(posedge pclk) disable iff (!presetn)
      (s.rl == rlsr_pkg::remote_state) && ren && key_force
      |=> s.rl == rlsr_pkg::local_state;
  endproperty
  a_key_local: assert property (p_key_local) else $error("key kept remote");
  property p_llo;
    @(posedge pclk) disable iff (!presetn)
      (s.rl == rlsr_pkg::remote_state) && ren && llo && !gtl && !key_force
      |=> s.rl == rlsr_pkg::remote_lockout_state;
  endproperty
  a_llo: assert property (p_llo) else $error("llo not taken");
  property p_local_lockout_state_dark;
    @(posedge pclk) disable iff (!presetn)
      s.rl == rlsr_pkg::local_lockout_state |-> !remote_ind && !setting_en;
  endproperty
  a_local_lockout_state_dark: assert property (p_local_lockout_state_dark) else $error("lockout lit");
  property p_remote_lockout_state_keys;
    @(posedge pclk) disable iff (!presetn)
      (s.rl == rlsr_pkg::remote_lockout_state) && ren && !gtl && key_press
      |=> (s.rl == rlsr_pkg::remote_lockout_state) && remote_ind;
  endproperty
  a_remote_lockout_state_keys: assert property (p_remote_lockout_state_keys) else $error("key left lockout");
  property p_gtl_remote_lockout_state;
    @(posedge pclk) disable iff (!presetn)
      (s.rl == rlsr_pkg::remote_lockout_state) && ren && gtl
      |=> s.rl == rlsr_pkg::local_lockout_state;
  endproperty
  a_gtl_remote_lockout_state: assert property (p_gtl_remote_lockout_state) else $error("gtl wrong state");
  property p_pwr_dcl;
    @(posedge pclk) disable iff (!presetn)
      s.pend[rlsr_pkg::CL_PWR] && dcl && !poll_read && !q.pop
      |=> s.pend[rlsr_pkg::CL_PWR];
  endproperty
  a_pwr_dcl: assert property (p_pwr_dcl) else $error("power-on lost on clear");
  property p_reject;
    @(posedge pclk) disable iff (!presetn)
      acc && pwrite && paddr == rlsr_pkg::ADR_CMD && local_any &&
      pwdata[1:0] == rlsr_pkg::KIND_SETTING
      |=> s.rejected && s.pend[rlsr_pkg::CL_EXE] && stb_byte != rlsr_pkg::STB_NONE;
  endproperty
  a_reject: assert property (p_reject) else $error("local setting not refused");
  property p_srq;
    @(posedge pclk) disable iff (!presetn)
      srq |-> s.service_request_enable && (s.pend != '0) && stb_byte[6];
  endproperty
  a_srq: assert property (p_srq) else $error("srq without cause");
endmodule
`default_nettype wire

// ==== rlsr_gpib_ctl.sv ====
`timescale 1ns/1ps
`default_nettype none
module rlsr_gpib_ctl (
  // clock
  input  wire logic       pclk,
  // gpib lines
  output logic            ren,
  output logic            atn,
  output logic            ifc,
  output logic            bus_strobe,
  output logic      [7:0] bus_byte,
  output logic            poll_read
);
  initial begin
    ren = 1'b0;
    atn = 1'b0;
    ifc = 1'b0;
    bus_strobe = 1'b0;
    bus_byte = 8'h00;
    poll_read = 1'b0;
  end
  // one message byte under atn, then line released
  task automatic msg(input logic [7:0] b);
    @(posedge pclk);
    atn <= 1'b1;
    bus_strobe <= 1'b1;
    bus_byte <= b;
    @(posedge pclk);
    atn <= 1'b0;
    bus_strobe <= 1'b0;
    bus_byte <= ~b;
    @(posedge pclk);
  endtask
  // remote enable level
  task automatic set_ren(input logic v);
    ren <= v;
  endtask
  // one-cycle interface clear
  task automatic pulse_ifc();
    @(posedge pclk);
    ifc <= 1'b1;
    @(posedge pclk);
    ifc <= 1'b0;
    @(posedge pclk);
  endtask
  // serial poll: enable, talk address, read byte
  task automatic poll(input logic [7:0] mta);
    msg(rlsr_pkg::GP_SPE);
    msg(mta);
    poll_read <= 1'b1;
    @(posedge pclk);
    poll_read <= 1'b0;
    @(posedge pclk);
    @(posedge pclk);
  endtask
endmodule
`default_nettype wire

// ==== remote_local_status_reporter_tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin num_errors++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
module remote_local_status_reporter_tb_top;
  localparam logic [7:0] MLA = rlsr_pkg::GP_MLA | {3'h0, rlsr_pkg::ADDR_RST};
  localparam logic [7:0] MTA = rlsr_pkg::GP_MTA | {3'h0, rlsr_pkg::ADDR_RST};
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] rd;
  logic        err;
  logic        key_press = 1'b0;
  logic [7:0]  evt = 8'h00;
  wire logic [31:0] prdata;
  wire logic [7:0]  stb_byte;
  wire logic        pready, pslverr, ren, atn, ifc, bus_strobe, poll_read;
  wire logic        srq, remote_ind, setting_en, talk_active, poll_mode, listen_active;
  wire logic [7:0]  bus_byte;
  int num_errors = 0;
  int compares = 0;
  int cyc = 0;
  always #5 pclk = ~pclk;
  rlsr_top i_rlsr_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ren(ren), .atn(atn),
    .ifc(ifc), .bus_strobe(bus_strobe), .bus_byte(bus_byte),
    .poll_read(poll_read), .key_press(key_press), .key_exempt(1'b0),
    .evt(evt), .srq(srq), .stb_byte(stb_byte), .remote_ind(remote_ind),
    .setting_en(setting_en), .listen_active(listen_active), .talk_active(talk_active),
    .poll_mode(poll_mode));
  rlsr_gpib_ctl i_rlsr_gpib_ctl (.pclk(pclk), .ren(ren), .atn(atn), .ifc(ifc),
    .bus_strobe(bus_strobe), .bus_byte(bus_byte), .poll_read(poll_read));
  task automatic summarize();
    $display("errors=%0d compares=%0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 3000) begin
      num_errors++;
      summarize();
    end
  end
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rl(input logic [1:0] e);
    apb(1'b0, rlsr_pkg::ADR_STATUS, 32'h0);
    `CHK(rd[25:24], e)
  endtask
  task automatic key();
    @(posedge pclk);
    key_press <= 1'b1;
    @(posedge pclk);
    key_press <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic t_states();
    i_rlsr_gpib_ctl.set_ren(1'b1);
    i_rlsr_gpib_ctl.msg(MLA);
    rl(2'h1);
    `CHK(remote_ind, 1'b1)
    `CHK(setting_en, 1'b1)
    apb(1'b1, rlsr_pkg::ADR_CMD, 32'h7);
    key();
    rl(2'h0);
    apb(1'b0, rlsr_pkg::ADR_ERRQ, 32'h0);
    `CHK(rd[9:0], 10'h0CA)
    i_rlsr_gpib_ctl.msg(rlsr_pkg::GP_LLO);
    rl(2'h2);
    `CHK(remote_ind, 1'b0)
    i_rlsr_gpib_ctl.msg(MLA);
    key();
    rl(2'h3);
    `CHK(remote_ind, 1'b1)
    i_rlsr_gpib_ctl.msg(rlsr_pkg::GP_GTL);
    rl(2'h2);
    i_rlsr_gpib_ctl.set_ren(1'b0);
    rl(2'h0);
  endtask
  task automatic t_events();
    apb(1'b1, rlsr_pkg::ADR_CTRL, 32'h0000_1005);
    @(posedge pclk);
    `CHK(stb_byte, 8'h72)
    apb(1'b1, rlsr_pkg::ADR_POST, 32'h0000_0065);
    @(posedge pclk);
    `CHK(stb_byte, 8'h71)
    i_rlsr_gpib_ctl.msg(rlsr_pkg::GP_DCL);
    `CHK(stb_byte, 8'h10)
    `CHK(srq, 1'b0)
    @(posedge pclk);
    evt <= 8'h01;
    @(posedge pclk);
    evt <= 8'h00;
    @(posedge pclk);
    `CHK(stb_byte, 8'h52)
    `CHK(srq, 1'b1)
    apb(1'b0, rlsr_pkg::ADR_ERRQ, 32'h0);
    `CHK(rd[9:0], 10'h192)
    `CHK(listen_active, 1'b1)
    i_rlsr_gpib_ctl.msg(rlsr_pkg::GP_UNL);
    `CHK(listen_active, 1'b0)
  endtask
  task automatic t_status();
    `CHK(stb_byte, 8'h41)
    `CHK(srq, 1'b1)
    apb(1'b1, rlsr_pkg::ADR_CMD, 32'h1);
    apb(1'b0, rlsr_pkg::ADR_CMD, 32'h0);
    `CHK(rd[0], 1'b1)
    apb(1'b1, rlsr_pkg::ADR_CMD, 32'h0);
    apb(1'b0, rlsr_pkg::ADR_CMD, 32'h0);
    `CHK(rd[0], 1'b0)
    `CHK(stb_byte, 8'h41)
    i_rlsr_gpib_ctl.poll(MTA);
    `CHK(stb_byte, 8'h62)
    `CHK(srq, 1'b1)
    apb(1'b0, rlsr_pkg::ADR_ERRQ, 32'h0);
    `CHK(rd[9:0], 10'h0C9)
    apb(1'b0, 8'hFC, 32'h0);
    `CHK(err, 1'b1)
    i_rlsr_gpib_ctl.msg(rlsr_pkg::GP_SPD);
    `CHK(poll_mode, 1'b0)
    i_rlsr_gpib_ctl.pulse_ifc();
    `CHK(talk_active, 1'b0)
  endtask
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_status();
    t_states();
    t_events();
    summarize();
  end
endmodule
`default_nettype wire
